// ===== idac_map.svh
`ifndef IDAC_MAP_SVH
`define IDAC_MAP_SVH

// Address byte values of the serial input shift register
`define IDAC_ADDR_DATA 8'h01
`define IDAC_ADDR_READ 8'h02
`define IDAC_ADDR_CTRL 8'h55
`define IDAC_ADDR_RST 8'h56

// Read-back selection, low two data bits of a read frame
`define IDAC_RDSEL_STATUS 2'h0
`define IDAC_RDSEL_DATA 2'h1
`define IDAC_RDSEL_CTRL 2'h2

// Frame layout
`define IDAC_FRAME_BITS 5'h18
`define IDAC_ADDR_MSB 23
`define IDAC_ADDR_LSB 16
`define IDAC_RST_BIT 0

// Range select codes
`define IDAC_RANGE_4_20 3'h5
`define IDAC_RANGE_0_20 3'h6
`define IDAC_RANGE_0_24 3'h7

// Data register mask: 16-bit variant; the 12-bit variant uses 16'hFFF0
`define IDAC_DATA_MASK 16'hFFFF
`define IDAC_CTRL_MASK 16'h3FFF

// Reset values
`define IDAC_CTRL_RESET 16'h0000
`define IDAC_DATA_RESET 16'h0000
`define IDAC_ZERO_SCALE 16'h0000

// Slew update period is (sr_clock + 1) times this many clk cycles
`define IDAC_SLEW_BASE_CYC 16'h0040

// Synchroniser lane positions
`define IDAC_SY_SCLK 0
`define IDAC_SY_SDIN 1
`define IDAC_SY_LATCH 2
`define IDAC_SY_CLEAR 3
`define IDAC_SY_HEADROOM 4
`define IDAC_SY_OVERTEMP 5
`define IDAC_SY_WIDTH 6

`endif

// ===== idac_pkg.sv
package idac_pkg;

  typedef struct packed {
    logic [1:0] zero;
    logic external_resistor_select;
    logic output_enable_bit;
    logic [3:0] sr_clock;
    logic [2:0] sr_step;
    logic slew_control_enable;
    logic daisy_chain_enable;
    logic [2:0] range_select;
  } idac_ctrl_t;

  typedef struct packed {
    logic [12:0] reserved;
    logic iout_fault;
    logic slew_active;
    logic overtemp;
  } idac_status_t;

  typedef struct packed {
    logic sclk;
    logic sdin;
    logic latch_n;
  } idac_serial_t;

  typedef struct packed {
    logic [15:0] dac_code;
    logic [2:0] range_select;
    logic current_output_enable;
    logic external_resistor_select;
    logic hart_path_enable;
  } idac_analog_t;

endpackage

// ===== idac_sync.sv
module idac_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } idac_sync_state_t;

  idac_sync_state_t s;
  idac_sync_state_t next_s;

  // First stage feeds only the second stage
  always_comb begin
    next_s.first = async_in;
    next_s.second = s.first;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sync_out = s.second;

endmodule // idac_sync

// ===== idac_top.sv
`include "idac_map.svh"

module idac_top
  import idac_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Serial port pins
  input wire logic sclk,
  input wire logic sdin,
  input wire logic latch_n,
  output logic sdo,
  // Asynchronous clear pin, active high
  input wire logic clear,
  // Analog detectors
  input wire logic headroom_low,
  input wire logic overtemp_detect,
  // Analog controls
  output logic [15:0] dac_code,
  output logic [2:0] range_select,
  output logic current_output_enable,
  output logic external_resistor_select,
  output logic hart_path_enable,
  // Open-drain fault alert
  output logic fault_o,
  output logic fault_oe
);

  typedef struct packed {
    idac_ctrl_t ctrl;
    logic [15:0] data_reg;
    logic [15:0] cur;
    logic cleared;
    logic [23:0] shift_in;
    logic [4:0] bit_cnt;
    logic [15:0] rd_shift;
    logic sdo;
    logic sclk_q;
    logic latch_q;
    logic [15:0] tick_cnt;
    idac_status_t status;
    idac_analog_t analog;
    logic fault_low;
    logic fault_oe;
  } idac_state_t;

  idac_state_t s;
  idac_state_t next_s;
  logic [`IDAC_SY_WIDTH-1:0] sy;
  idac_serial_t ser;

  idac_sync #(
    .WIDTH(`IDAC_SY_WIDTH)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    // Latch lane travels inverted so the reset value of the pipe means idle
    .async_in({overtemp_detect, headroom_low, clear, ~latch_n, sdin, sclk}),
    .sync_out(sy)
  );

  assign ser.sclk = sy[`IDAC_SY_SCLK];
  assign ser.sdin = sy[`IDAC_SY_SDIN];
  assign ser.latch_n = ~sy[`IDAC_SY_LATCH];

  function automatic idac_state_t power_on_state();
    idac_state_t r;
    r = '0;
    r.ctrl = idac_ctrl_t'(`IDAC_CTRL_RESET);
    r.data_reg = `IDAC_DATA_RESET;
    r.cur = `IDAC_ZERO_SCALE;
    // Latch idles high, so no false edge after reset
    r.latch_q = 1'b1;
    return r;
  endfunction

  function automatic logic range_valid(input logic [2:0] code);
    logic ok;
    ok = 1'b0;
    case (code)
      `IDAC_RANGE_4_20: ok = 1'b1;
      `IDAC_RANGE_0_20: ok = 1'b1;
      `IDAC_RANGE_0_24: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Frame counts as complete once a whole word was clocked in
  function automatic logic frame_complete(input logic [4:0] cnt);
    return cnt >= `IDAC_FRAME_BITS;
  endfunction

  // Word loaded into the read shifter by a read frame
  function automatic logic [15:0] readback_word(
    input logic [1:0] sel,
    input idac_status_t st,
    input logic [15:0] dat,
    input idac_ctrl_t ctl
  );
    logic [15:0] w;
    w = 16'h0000;
    case (sel)
      `IDAC_RDSEL_STATUS: w = st;
      `IDAC_RDSEL_DATA: w = dat;
      `IDAC_RDSEL_CTRL: w = ctl;
      default: w = 16'h0000;
    endcase
    return w;
  endfunction

  // Step size doubles with each step code
  function automatic logic [15:0] slew_step(input logic [2:0] code);
    return 16'h0001 << code;
  endfunction

  // Update period in clk cycles; top code gives the slowest ramp
  function automatic logic [15:0] slew_period(input logic [3:0] code);
    logic [15:0] n;
    n = 16'(code) + 16'h0001;
    return n * `IDAC_SLEW_BASE_CYC;
  endfunction

  // One step from cur toward tgt, clamped so it never overshoots
  function automatic logic [15:0] slew_move(
    input logic [15:0] cur,
    input logic [15:0] tgt,
    input logic [15:0] stp
  );
    logic [16:0] up;
    logic [15:0] r;
    up = {1'b0, cur} + {1'b0, stp};
    r = tgt;
    if (cur < tgt) begin
      if (up < {1'b0, tgt}) begin
        r = up[15:0];
      end
    end else if (cur - tgt > stp) begin
      r = cur - stp;
    end
    return r;
  endfunction

  // Live status word; reserved bits always read zero
  function automatic idac_status_t status_word(
    input logic fault,
    input logic slewing,
    input logic hot
  );
    idac_status_t w;
    w = '0;
    w.reserved = 13'h0000;
    w.iout_fault = fault;
    w.slew_active = slewing;
    w.overtemp = hot;
    return w;
  endfunction

  // Output and its coupled path share one enable
  function automatic idac_analog_t analog_word(
    input logic [15:0] code,
    input idac_ctrl_t ctl,
    input logic on
  );
    idac_analog_t a;
    a = '0;
    a.dac_code = code;
    a.range_select = ctl.range_select;
    a.current_output_enable = on;
    a.external_resistor_select = ctl.external_resistor_select;
    a.hart_path_enable = on;
    return a;
  endfunction

  // Daisy chain passes the oldest shifted bit on, else the read-back MSB
  function automatic logic serial_out(
    input logic chain,
    input logic [23:0] shifted,
    input logic [15:0] readback
  );
    return chain ? shifted[23] : readback[15];
  endfunction

  logic sclk_rise;
  logic latch_rise;
  logic latch_fall;
  logic clear_in;
  logic soft_reset;
  logic path_on;
  logic [7:0] frame_addr;
  logic [15:0] frame_data;
  logic [15:0] target;
  logic [15:0] step;
  logic [15:0] period;

  always_comb begin
    next_s = s;
    soft_reset = 1'b0;
    clear_in = sy[`IDAC_SY_CLEAR];
    sclk_rise = ser.sclk & ~s.sclk_q;
    latch_rise = ser.latch_n & ~s.latch_q;
    latch_fall = ~ser.latch_n & s.latch_q;
    frame_addr = s.shift_in[`IDAC_ADDR_MSB:`IDAC_ADDR_LSB];
    frame_data = s.shift_in[15:0];
    next_s.sclk_q = ser.sclk;
    next_s.latch_q = ser.latch_n;

    // Serial shifting while the latch is low
    if (latch_fall) begin
      next_s.bit_cnt = 5'h00;
    end
    if (sclk_rise && !ser.latch_n) begin
      next_s.shift_in = {s.shift_in[22:0], ser.sdin};
      next_s.rd_shift = {s.rd_shift[14:0], 1'b0};
      if (s.bit_cnt != 5'h1F) begin
        next_s.bit_cnt = s.bit_cnt + 5'h01;
      end
    end

    // Frame decode on the latch rising edge
    if (latch_rise) begin
      if (s.bit_cnt == 5'h00) begin
        // Bare latch pulse brings back the held data value
        if (!clear_in) begin
          next_s.cleared = 1'b0;
        end
      end else if (frame_complete(s.bit_cnt)) begin
        case (frame_addr)
          `IDAC_ADDR_DATA: begin
            // Refused while clear is high; a fresh value also ends the hold
            if (!clear_in) begin
              next_s.data_reg = frame_data & `IDAC_DATA_MASK;
              next_s.cleared = 1'b0;
            end
          end
          `IDAC_ADDR_CTRL: begin
            next_s.ctrl = idac_ctrl_t'(frame_data & `IDAC_CTRL_MASK);
          end
          `IDAC_ADDR_RST: begin
            // Only the reset bit is looked at
            soft_reset = frame_data[`IDAC_RST_BIT];
          end
          `IDAC_ADDR_READ: begin
            next_s.rd_shift = readback_word(frame_data[1:0], s.status, s.data_reg, s.ctrl);
          end
          // Status and unknown addresses: nothing is written
          default: next_s.status = s.status;
        endcase
      end
    end

    // Clear holds the output at range bottom and keeps holding after release
    if (clear_in) begin
      next_s.cleared = 1'b1;
    end

    path_on = s.ctrl.output_enable_bit & range_valid(s.ctrl.range_select);
    // Code zero is the bottom of every supported range
    target = (next_s.cleared || !path_on) ? `IDAC_ZERO_SCALE : s.data_reg;

    // Slew engine: steps of 2^sr_step every (sr_clock+1) base periods
    step = slew_step(s.ctrl.sr_step);
    period = slew_period(s.ctrl.sr_clock);
    // A disabled output has nothing to ramp, so it drops straight to zero
    if (!s.ctrl.slew_control_enable || !path_on) begin
      next_s.cur = target;
      next_s.tick_cnt = 16'h0000;
    end else if (s.cur == target) begin
      next_s.tick_cnt = 16'h0000;
    end else if (s.tick_cnt + 16'h0001 >= period) begin
      next_s.tick_cnt = 16'h0000;
      // Ramp toward target, including the ramp down on clear
      next_s.cur = slew_move(s.cur, target, step);
    end else begin
      next_s.tick_cnt = s.tick_cnt + 16'h0001;
    end

    // Status flags follow their causes, not sticky
    next_s.status = status_word(sy[`IDAC_SY_HEADROOM],
      s.ctrl.slew_control_enable && (next_s.cur != target), sy[`IDAC_SY_OVERTEMP]);

    // Open-drain: only ever pull low, several devices share one pull-up
    next_s.fault_low = 1'b0;
    next_s.fault_oe = sy[`IDAC_SY_HEADROOM] | sy[`IDAC_SY_OVERTEMP];

    // Analog controls
    next_s.analog = analog_word(next_s.cur, s.ctrl, path_on);

    // One serial output serves both read-back and daisy chain
    next_s.sdo = serial_out(s.ctrl.daisy_chain_enable, next_s.shift_in, next_s.rd_shift);

    if (soft_reset) begin
      next_s = power_on_state();
      next_s.sclk_q = ser.sclk;
      next_s.latch_q = ser.latch_n;
      // Detector copies are live levels, so a reset must not hide a fault
      next_s.status = status_word(sy[`IDAC_SY_HEADROOM], 1'b0, sy[`IDAC_SY_OVERTEMP]);
      next_s.fault_oe = sy[`IDAC_SY_HEADROOM] | sy[`IDAC_SY_OVERTEMP];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s <= power_on_state();
    end else begin
      s <= next_s;
    end
  end

  assign sdo = s.sdo;
  assign dac_code = s.analog.dac_code;
  assign range_select = s.analog.range_select;
  assign current_output_enable = s.analog.current_output_enable;
  assign external_resistor_select = s.analog.external_resistor_select;
  assign hart_path_enable = s.analog.hart_path_enable;
  assign fault_o = s.fault_low;
  assign fault_oe = s.fault_oe;

endmodule // idac_top

// ===== idac_host.sv
module idac_host (
  // Clock
  input wire logic clk,
  // Serial pins toward the device
  output logic sclk,
  output logic sdin,
  output logic latch_n,
  input wire logic sdo
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk = 1'b0;
    sdin = 1'b0;
    latch_n = 1'b1;
  end
  // Sdo taken just before each rising sclk, first sixteen bits kept
  task automatic frame(input int n, input logic [23:0] w, output logic [15:0] rd);
    rd = 16'h0000;
    @(negedge clk);
    latch_n = 1'b0;
    repeat (3) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      sdin = w[23-i];
      repeat (3) @(negedge clk);
      if (i < 16) rd = {rd[14:0], sdo};
      sclk = 1'b1;
      repeat (3) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (3) @(negedge clk);
    latch_n = 1'b1;
    // Released line must not keep showing the last bit
    sdin = ~sdin;
    repeat (8) @(negedge clk);
  endtask
endmodule // idac_host

// ===== idac_top_assertions.sv
module idac_top_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Watched pins
  input wire logic latch_n,
  input wire logic clear,
  input wire logic headroom_low,
  input wire logic overtemp_detect,
  input wire logic [15:0] dac_code,
  input wire logic [2:0] range_select,
  input wire logic current_output_enable,
  input wire logic external_resistor_select,
  input wire logic hart_path_enable,
  input wire logic fault_o,
  input wire logic fault_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_alert_on; (headroom_low || overtemp_detect)[*4] |=> fault_oe; endproperty
  a_alert_on: assert property (p_alert_on)
    else $error("alert not driven");
  property p_alert_off; (!headroom_low && !overtemp_detect)[*4] |=> !fault_oe; endproperty
  a_alert_off: assert property (p_alert_off)
    else $error("alert without cause");
  property p_open_drain; fault_o == 1'b0; endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("alert pin driven high");
  property p_hart; hart_path_enable == current_output_enable; endproperty
  a_hart: assert property (p_hart)
    else $error("hart path without output enable");
  property p_off_zero; !current_output_enable |-> dac_code == 16'h0000; endproperty
  a_off_zero: assert property (p_off_zero)
    else $error("code while output disabled");
  property p_range_ok; current_output_enable |-> range_select inside {3'h5, 3'h6, 3'h7}; endproperty
  a_range_ok: assert property (p_range_ok)
    else $error("output on with bad range");
  // Six samples cover the clear synchroniser and a frame already in flight
  property p_clear_refuse; clear[*6] |=> dac_code <= $past(dac_code); endproperty
  a_clear_refuse: assert property (p_clear_refuse)
    else $error("code rose while clear high");
  property p_clear_hold;
    (clear && latch_n && dac_code == 16'h0000)[*4] ##1 (!clear && latch_n)[*5]
      |=> dac_code == 16'h0000;
  endproperty
  a_clear_hold: assert property (p_clear_hold)
    else $error("cleared code left without load");
  property p_stable;
    (!latch_n)[*8] |=> $stable(range_select) && $stable(external_resistor_select);
  endproperty
  a_stable: assert property (p_stable)
    else $error("control outputs moved inside frame");
endmodule // idac_top_checker

bind idac_top idac_top_checker chk (.clk, .rstn, .latch_n, .clear, .headroom_low,
  .overtemp_detect, .dac_code, .range_select, .current_output_enable,
  .external_resistor_select, .hart_path_enable, .fault_o, .fault_oe);

// ===== testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [15:0] ctrl, data, code;
    logic [2:0] rng;
    logic en, ext;
  } idac_row_t;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic clear = 1'b0;
  logic headroom_low = 1'b0;
  logic overtemp_detect = 1'b0;
  logic sclk, sdin, latch_n, sdo, current_output_enable, external_resistor_select;
  logic hart_path_enable, fault_o, fault_oe;
  logic [15:0] dac_code, rd;
  logic [2:0] range_select;
  int fail_count = 0;
  int comparisons = 0;
  idac_row_t rows [6] = '{
    '{16'h1005, 16'h1234, 16'h1234, 3'h5, 1'b1, 1'b0},
    '{16'h3006, 16'hFFFF, 16'hFFFF, 3'h6, 1'b1, 1'b1},
    '{16'h1007, 16'h8001, 16'h8001, 3'h7, 1'b1, 1'b0},
    '{16'h1003, 16'h5555, 16'h0000, 3'h3, 1'b0, 1'b0},
    '{16'h3004, 16'h5555, 16'h0000, 3'h4, 1'b0, 1'b1},
    '{16'h0005, 16'h00AB, 16'h0000, 3'h5, 1'b0, 1'b0}};
  always #2 clk = ~clk;
  idac_top dut (.clk, .rstn, .sclk, .sdin, .latch_n, .sdo, .clear, .headroom_low,
    .overtemp_detect, .dac_code, .range_select, .current_output_enable,
    .external_resistor_select, .hart_path_enable, .fault_o, .fault_oe);
  idac_host host (.clk, .sclk, .sdin, .latch_n, .sdo);
  task automatic check(input string name, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host.frame(24, {a, d}, rd);
  endtask
  // Read-back needs a second frame to shift the word out
  task automatic status(input logic [15:0] exp);
    wr(8'h02, 16'h0000);
    wr(8'h00, 16'h0000);
    check("status", rd, exp);
  endtask
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #240000;
    fail_count++;
    stop_test();
  end
  initial begin
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    check("reset code", dac_code, 16'h0000);
    foreach (rows[i]) begin
      wr(8'h55, rows[i].ctrl);
      wr(8'h01, rows[i].data);
      check("code", dac_code, rows[i].code);
      check("range", 16'(range_select), 16'(rows[i].rng));
      check("enable", 16'(current_output_enable), 16'(rows[i].en));
      check("external_resistor_select", 16'(external_resistor_select), 16'(rows[i].ext));
      check("hart", 16'(hart_path_enable), 16'(rows[i].en));
    end
    wr(8'h55, 16'h1005);
    wr(8'h01, 16'h4321);
    clear = 1'b1;
    repeat (20) @(negedge clk);
    check("cleared", dac_code, 16'h0000);
    wr(8'h01, 16'h1111);
    check("load in clear", dac_code, 16'h0000);
    clear = 1'b0;
    repeat (10) @(negedge clk);
    check("held", dac_code, 16'h0000);
    host.frame(0, 24'h000000, rd);
    check("restored", dac_code, 16'h4321);
    wr(8'h02, 16'h0001);
    wr(8'h00, 16'h0000);
    check("data read", rd, 16'h4321);
    wr(8'h02, 16'h0002);
    wr(8'h00, 16'h0000);
    check("ctrl read", rd, 16'h1005);
    // Daisy mode echoes the previous frame on the serial output
    wr(8'h55, 16'h100D);
    wr(8'h00, 16'h0000);
    check("daisy", rd, 16'h5510);
    wr(8'h56, 16'hFFFE);
    check("reserved reset", dac_code, 16'h4321);
    wr(8'h56, 16'h0001);
    check("soft reset", dac_code, 16'h0000);
    check("soft range", 16'(range_select), 16'h0000);
    headroom_low = 1'b1;
    repeat (8) @(negedge clk);
    check("alert", 16'(fault_oe), 16'h0001);
    status(16'h0004);
    headroom_low = 1'b0;
    overtemp_detect = 1'b1;
    repeat (8) @(negedge clk);
    check("alert", 16'(fault_oe), 16'h0001);
    status(16'h0001);
    overtemp_detect = 1'b0;
    repeat (8) @(negedge clk);
    check("alert off", 16'(fault_oe), 16'h0000);
    wr(8'h55, 16'h1015);
    wr(8'h01, 16'h0100);
    status(16'h0002);
    // 256 one-LSB steps at 64 clk each
    repeat (17000) @(negedge clk);
    check("slew end", dac_code, 16'h0100);
    status(16'h0000);
    stop_test();
  end
endmodule // testbench
